// ===== include/mfrtc_pkg.sv
// Register map, field layout and encodings of the FIFO configuration bank
package mfrtc_pkg;
  // Byte addresses on the register port
  localparam logic [7:0] RECV_CONF_OFS = 8'h6c;
  localparam logic [7:0] XMIT_CONF_OFS = 8'h70;
  // Receive configuration fields
  localparam int CNT_LSB = 16;
  localparam int CNT_W = 12;
  localparam int RX_PURGE_BIT = 15;
  localparam int OFF_LSB = 8;
  localparam int OFF_W = 5;
  localparam int ALIGN_LSB = 30;
  localparam int ALIGN_W = 2;
  // Transmit configuration fields
  localparam int TXS_PURGE_BIT = 15;
  localparam int TXD_PURGE_BIT = 14;
  localparam int PERMIT_BIT = 2;
  localparam int ENABLE_BIT = 1;
  localparam int STOP_BIT = 0;
  // End alignment codes and the DWORD masks they give
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [2:0] MASK_4 = 3'h0;
  localparam logic [2:0] MASK_16 = 3'h3;
  localparam logic [2:0] MASK_32 = 3'h7;
  // Reset values
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [4:0] OFF_RST = 5'h00;
  localparam logic [1:0] ALIGN_RST = 2'h0;
endpackage

// ===== src/mfrtc_xfer_counter.sv
// Loadable down counter that signals once when it drains to zero
`timescale 1ns/1ps
module mfrtc_xfer_counter #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic dec,
  output logic [W-1:0] count,
  output logic zero_event
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic evt;
  } mfrtc_cnt_type;

  mfrtc_cnt_type q, d;

  always_comb begin
    d = q;
    d.evt = 1'b0;
    if (load) begin
      d.cnt = load_value;
    end else if (dec && q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      d.evt = (q.cnt == W'(1));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;
  assign zero_event = q.evt;

  // ==========================================================
  // Checks
  property p_drain;
    @(posedge core_clk) disable iff (!rst_n)
    dec && !load && q.cnt == W'(1) |=> zero_event && count == '0;
  endproperty
  a_drain: assert property (p_drain) else $error("count did not signal at zero");
  property p_hold_zero;
    @(posedge core_clk) disable iff (!rst_n)
    q.cnt == '0 && !load |=> count == '0 && !zero_event;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("zero count moved");
  property p_load;
    @(posedge core_clk) disable iff (!rst_n)
    load |=> count == $past(load_value);
  endproperty
  a_load: assert property (p_load) else $error("written count not taken");
  property p_step;
    @(posedge core_clk) disable iff (!rst_n)
    dec && !load && q.cnt != '0 |=> count == $past(q.cnt) - 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("count did not step down");
endmodule

// ===== src/mfrtc_tx_ctrl.sv
// Transmitter enable and graceful stop control
`timescale 1ns/1ps
module mfrtc_tx_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic wr_enable,
  input wire logic wr_stop,
  input wire logic permit,
  input wire logic status_full,
  input wire logic tx_idle,
  output logic enable,
  output logic stop_req,
  output logic run,
  output logic halted
);
  typedef struct packed {
    logic on;
    logic stop;
    logic run;
    logic halted;
  } mfrtc_tx_type;

  mfrtc_tx_type q, d;

  always_comb begin
    d = q;
    d.halted = 1'b0;
    if (wr) begin
      d.on = wr_enable;
      if (!q.stop && wr_stop) begin
        d.stop = 1'b1;
      end
    end
    // Stop waits for the frame in flight to finish
    if (q.stop && tx_idle) begin
      d.on = 1'b0;
      d.stop = 1'b0;
      d.halted = 1'b1;
    end
    d.run = d.on && (permit || !status_full);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign enable = q.on;
  assign stop_req = q.stop;
  assign run = q.run;
  assign halted = q.halted;

  // ==========================================================
  // Checks
  property p_stop_hold;
    @(posedge core_clk) disable iff (!rst_n)
    q.stop && !tx_idle |=> stop_req;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop request dropped early");
  property p_halt;
    @(posedge core_clk) disable iff (!rst_n)
    q.stop && tx_idle |=> !enable && !stop_req && halted;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not clear bits");
  property p_suspend;
    @(posedge core_clk) disable iff (!rst_n)
    status_full && !permit |=> !run;
  endproperty
  a_suspend: assert property (p_suspend) else $error("ran with full status fifo");
  property p_run;
    @(posedge core_clk) disable iff (!rst_n)
    enable && permit && !(q.stop && tx_idle) && !wr |=> run;
  endproperty
  a_run: assert property (p_run) else $error("enabled transmitter not running");
  c_halt: cover property (@(posedge core_clk) disable iff (!rst_n) halted);
endmodule

// ===== src/mfrtc_top.sv
// Receive and transmit FIFO configuration register bank
// How it works
// - Twelve-bit receive DWORD count sits in bits 27-16 of receive configuration.
// - Each host DWORD read from the receive data FIFO decrements the count until it reaches zero.
// - A host write reloads the count at any time, replacing the running value.
// - Writing one to bit 15 purges receive data and status FIFOs, self-clearing.
// - Bits 12-8 give a 0-31 byte offset before each received packet.
// - Upper three offset bits may change live; applied at the next DWORD read.
// - End alignment codes: 00 four, 01 sixteen, 10 thirty-two bytes; 11 reserved.
// - Filler DWORDs follow a buffer's last data up to the alignment in 31:30.
// - Writing one to transmit bit 15 purges the transmit status FIFO.
// - Writing one to transmit bit 14 purges the transmit data FIFO.
// - Bit 2 clear suspends transmission on a full status FIFO; set continues.
// - The overrun permit bit never affects the status FIFO full event.
// - Bit 1 set enables the transmitter to send the data held.
// - Enable bit clears itself once a stop was requested and transmission halted.
// - Bit 0 finishes the current frame then stops; clears when stopped.
// - Host writes to the stop bit are ignored while it reads high.
`timescale 1ns/1ps
module mfrtc_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic rx_data_read,
  input wire logic rx_packet_start,
  input wire logic rx_last_read,
  input wire logic tx_status_full,
  input wire logic tx_idle,
  output logic rx_dma_event,
  output logic rx_fifo_purge,
  output logic [2:0] rx_dword_offset,
  output logic [1:0] rx_byte_offset,
  output logic [2:0] rx_pad_count,
  output logic rx_pad_valid,
  output logic transmit_status_purge,
  output logic tx_data_purge,
  output logic tx_enable,
  output logic tx_stop_req,
  output logic tx_run,
  output logic tx_halted,
  output logic tx_status_full_event
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] rdata;
    logic [1:0] align;
    logic [4:0] offset;
    logic rx_purge;
    logic txs_purge;
    logic txd_purge;
    logic permit;
    logic [2:0] dw_app;
    logic [1:0] byte_app;
    logic [2:0] pkt_cnt;
    logic [2:0] pad;
    logic pad_valid;
    logic full_prev;
    logic full_evt;
  } mfrtc_state_type;

  mfrtc_state_type q, d;

  logic wr_rx;
  logic wr_tx;
  logic [11:0] receive_transfer_count;
  logic [2:0] align_mask;
  logic [2:0] dw_done;

  assign wr_rx = reg_cs && reg_wr && reg_addr == mfrtc_pkg::RECV_CONF_OFS;
  assign wr_tx = reg_cs && reg_wr && reg_addr == mfrtc_pkg::XMIT_CONF_OFS;

  // ==========================================================
  // Receive DWORD count
  mfrtc_xfer_counter #(
    .W(mfrtc_pkg::CNT_W)
  ) u_count (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(wr_rx),
    .load_value(reg_wdata[mfrtc_pkg::CNT_LSB +: mfrtc_pkg::CNT_W]),
    .dec(rx_data_read),
    .count(receive_transfer_count),
    .zero_event(rx_dma_event)
  );

  // ==========================================================
  // Transmitter control
  mfrtc_tx_ctrl u_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr(wr_tx),
    .wr_enable(reg_wdata[mfrtc_pkg::ENABLE_BIT]),
    .wr_stop(reg_wdata[mfrtc_pkg::STOP_BIT]),
    .permit(q.permit),
    .status_full(tx_status_full),
    .tx_idle(tx_idle),
    .enable(tx_enable),
    .stop_req(tx_stop_req),
    .run(tx_run),
    .halted(tx_halted)
  );

  // ==========================================================
  // Alignment decode
  always_comb begin
    unique case (q.align)
      mfrtc_pkg::ALIGN_4: align_mask = mfrtc_pkg::MASK_4;
      mfrtc_pkg::ALIGN_16: align_mask = mfrtc_pkg::MASK_16;
      mfrtc_pkg::ALIGN_32: align_mask = mfrtc_pkg::MASK_32;
      default: align_mask = mfrtc_pkg::MASK_4;
    endcase
  end

  // DWORDs of this buffer including the last one being read
  assign dw_done = q.pkt_cnt + 3'h1;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.rx_purge = 1'b0;
    d.txs_purge = 1'b0;
    d.txd_purge = 1'b0;
    d.pad_valid = 1'b0;
    if (wr_rx) begin
      d.align = reg_wdata[mfrtc_pkg::ALIGN_LSB +: mfrtc_pkg::ALIGN_W];
      d.offset = reg_wdata[mfrtc_pkg::OFF_LSB +: mfrtc_pkg::OFF_W];
      d.rx_purge = reg_wdata[mfrtc_pkg::RX_PURGE_BIT];
    end
    if (wr_tx) begin
      d.txs_purge = reg_wdata[mfrtc_pkg::TXS_PURGE_BIT];
      d.txd_purge = reg_wdata[mfrtc_pkg::TXD_PURGE_BIT];
      d.permit = reg_wdata[mfrtc_pkg::PERMIT_BIT];
    end
    // Low offset bits follow the field; host keeps them still while running
    d.byte_app = q.offset[1:0];
    if (rx_data_read) begin
      d.dw_app = q.offset[4:2];
    end
    if (rx_packet_start) begin
      d.pkt_cnt = 3'h0;
    end else if (rx_data_read) begin
      d.pkt_cnt = dw_done;
    end
    if (rx_last_read) begin
      d.pad = (3'h0 - dw_done) & align_mask;
      d.pad_valid = 1'b1;
    end
    if (q.rx_purge) begin
      d.pkt_cnt = 3'h0;
    end
    // Full event ignores the permit bit
    d.full_prev = tx_status_full;
    d.full_evt = tx_status_full && !q.full_prev;
    d.rdata = 32'h0000_0000;
    if (reg_cs && reg_rd) begin
      if (reg_addr == mfrtc_pkg::RECV_CONF_OFS) begin
        d.rdata[mfrtc_pkg::ALIGN_LSB +: mfrtc_pkg::ALIGN_W] = q.align;
        d.rdata[mfrtc_pkg::CNT_LSB +: mfrtc_pkg::CNT_W] = receive_transfer_count;
        d.rdata[mfrtc_pkg::RX_PURGE_BIT] = q.rx_purge;
        d.rdata[mfrtc_pkg::OFF_LSB +: mfrtc_pkg::OFF_W] = q.offset;
      end else if (reg_addr == mfrtc_pkg::XMIT_CONF_OFS) begin
        d.rdata[mfrtc_pkg::TXS_PURGE_BIT] = q.txs_purge;
        d.rdata[mfrtc_pkg::TXD_PURGE_BIT] = q.txd_purge;
        d.rdata[mfrtc_pkg::PERMIT_BIT] = q.permit;
        d.rdata[mfrtc_pkg::ENABLE_BIT] = tx_enable;
        d.rdata[mfrtc_pkg::STOP_BIT] = tx_stop_req;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.align <= mfrtc_pkg::ALIGN_RST;
      q.offset <= mfrtc_pkg::OFF_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = q.rdata;
  assign rx_fifo_purge = q.rx_purge;
  assign rx_dword_offset = q.dw_app;
  assign rx_byte_offset = q.byte_app;
  assign rx_pad_count = q.pad;
  assign rx_pad_valid = q.pad_valid;
  assign transmit_status_purge = q.txs_purge;
  assign tx_data_purge = q.txd_purge;
  assign tx_status_full_event = q.full_evt;

  // ==========================================================
  // Checks
  property p_rx_purge;
    @(posedge core_clk) disable iff (!rst_n)
    wr_rx && reg_wdata[mfrtc_pkg::RX_PURGE_BIT] |=> rx_fifo_purge ##1 !rx_fifo_purge;
  endproperty
  a_rx_purge: assert property (p_rx_purge) else $error("receive purge not one pulse");

  property p_txs_purge;
    @(posedge core_clk) disable iff (!rst_n)
    wr_tx && reg_wdata[mfrtc_pkg::TXS_PURGE_BIT] |=> transmit_status_purge ##1 !transmit_status_purge;
  endproperty
  a_txs_purge: assert property (p_txs_purge) else $error("status purge missing");

  property p_txd_purge;
    @(posedge core_clk) disable iff (!rst_n)
    wr_tx && reg_wdata[mfrtc_pkg::TXD_PURGE_BIT] |=> tx_data_purge ##1 !tx_data_purge;
  endproperty
  a_txd_purge: assert property (p_txd_purge) else $error("data purge not one pulse");

  property p_dword_offset;
    @(posedge core_clk) disable iff (!rst_n)
    rx_data_read |=> rx_dword_offset == $past(q.offset[4:2]);
  endproperty
  a_dword_offset: assert property (p_dword_offset) else $error("dword offset not applied");

  property p_dword_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !rx_data_read |=> $stable(rx_dword_offset);
  endproperty
  a_dword_hold: assert property (p_dword_hold) else $error("dword offset moved early");

  property p_offset_write;
    @(posedge core_clk) disable iff (!rst_n)
    wr_rx |=> ##1 rx_byte_offset == $past(reg_wdata[9:8], 2);
  endproperty
  a_offset_write: assert property (p_offset_write) else $error("byte offset wrong");

  property p_pad32;
    @(posedge core_clk) disable iff (!rst_n)
    rx_last_read && q.align == mfrtc_pkg::ALIGN_32 && q.pkt_cnt == 3'h0
      |=> rx_pad_valid && rx_pad_count == 3'h7;
  endproperty
  a_pad32: assert property (p_pad32) else $error("32-byte filler wrong");

  property p_pad4;
    @(posedge core_clk) disable iff (!rst_n)
    rx_last_read && q.align == mfrtc_pkg::ALIGN_4 |=> rx_pad_count == 3'h0;
  endproperty
  a_pad4: assert property (p_pad4) else $error("4-byte filler not zero");

  property p_full_evt;
    @(posedge core_clk) disable iff (!rst_n)
    tx_status_full && !q.full_prev |=> tx_status_full_event;
  endproperty
  a_full_evt: assert property (p_full_evt) else $error("full event lost");

  property p_count_read;
    @(posedge core_clk) disable iff (!rst_n)
    reg_cs && reg_rd && reg_addr == mfrtc_pkg::RECV_CONF_OFS
      |=> reg_rdata[27:16] == $past(receive_transfer_count);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count readback wrong");

  property p_rx_quiet;
    @(posedge core_clk) disable iff (!rst_n)
    !(wr_rx && reg_wdata[mfrtc_pkg::RX_PURGE_BIT]) |=> !rx_fifo_purge;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("stray receive purge");

  property p_tx_quiet;
    @(posedge core_clk) disable iff (!rst_n)
    !wr_tx |=> !transmit_status_purge && !tx_data_purge;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("stray transmit purge");

  property p_purge_cnt;
    @(posedge core_clk) disable iff (!rst_n)
    q.rx_purge |=> q.pkt_cnt == 3'h0;
  endproperty
  a_purge_cnt: assert property (p_purge_cnt) else $error("purge kept packet count");

  property p_pkt_start;
    @(posedge core_clk) disable iff (!rst_n)
    rx_packet_start |=> q.pkt_cnt == 3'h0;
  endproperty
  a_pkt_start: assert property (p_pkt_start) else $error("packet count not cleared");

  // Data plus filler must land on the alignment boundary
  property p_pad16;
    @(posedge core_clk) disable iff (!rst_n)
    rx_last_read && q.align == mfrtc_pkg::ALIGN_16
      |=> rx_pad_valid && rx_pad_count <= 3'h3 && 2'(rx_pad_count + $past(dw_done)) == 2'h0;
  endproperty
  a_pad16: assert property (p_pad16) else $error("16-byte filler wrong");

  property p_pad32_sum;
    @(posedge core_clk) disable iff (!rst_n)
    rx_last_read && q.align == mfrtc_pkg::ALIGN_32 |=> 3'(rx_pad_count + $past(dw_done)) == 3'h0;
  endproperty
  a_pad32_sum: assert property (p_pad32_sum) else $error("32-byte filler misaligned");

  property p_pad_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
    rx_last_read && q.align == 2'h3 |=> rx_pad_count == 3'h0;
  endproperty
  a_pad_rsvd: assert property (p_pad_rsvd) else $error("reserved code padded");

  property p_pad_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !rx_last_read |=> !rx_pad_valid && $stable(rx_pad_count);
  endproperty
  a_pad_hold: assert property (p_pad_hold) else $error("filler count moved");

  property p_tx_read;
    @(posedge core_clk) disable iff (!rst_n)
    reg_cs && reg_rd && reg_addr == mfrtc_pkg::XMIT_CONF_OFS
      |=> reg_rdata[2:0] == {$past(q.permit), $past(tx_enable), $past(tx_stop_req)}
        && reg_rdata[31:16] == 16'h0000 && reg_rdata[13:3] == 11'h000;
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("transmit readback wrong");

  property p_rx_read;
    @(posedge core_clk) disable iff (!rst_n)
    reg_cs && reg_rd && reg_addr == mfrtc_pkg::RECV_CONF_OFS
      |=> reg_rdata[12:8] == $past(q.offset) && reg_rdata[31:30] == $past(q.align)
        && reg_rdata[29:28] == 2'h0 && reg_rdata[14:13] == 2'h0 && reg_rdata[7:0] == 8'h00;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive readback wrong");

  property p_full_once;
    @(posedge core_clk) disable iff (!rst_n)
    !tx_status_full || q.full_prev |=> !tx_status_full_event;
  endproperty
  a_full_once: assert property (p_full_once) else $error("spurious full event");

  property p_dma_once;
    @(posedge core_clk) disable iff (!rst_n)
    rx_dma_event |=> !rx_dma_event;
  endproperty
  a_dma_once: assert property (p_dma_once) else $error("receive event repeated");

  property p_align_keep;
    @(posedge core_clk) disable iff (!rst_n)
    !wr_rx |=> $stable(q.align);
  endproperty
  a_align_keep: assert property (p_align_keep) else $error("alignment moved");

  c_dma: cover property (@(posedge core_clk) disable iff (!rst_n) rx_dma_event);
  c_pad: cover property (@(posedge core_clk) disable iff (!rst_n)
    rx_pad_valid && rx_pad_count != 3'h0);
  c_suspend: cover property (@(posedge core_clk) disable iff (!rst_n)
    tx_enable && !tx_run);
  c_rx_purge: cover property (@(posedge core_clk) disable iff (!rst_n) rx_fifo_purge);
endmodule

// ===== tb/mfrtc_host_model.sv
// Host-side partner model: receive FIFO reader and transmit frame source
`timescale 1ns/1ps
module mfrtc_host_model (
  input wire logic core_clk,
  input wire logic pkt_go,
  input wire logic [3:0] pkt_len,
  input wire logic slow,
  input wire logic frame_go,
  output logic rx_data_read,
  output logic rx_packet_start,
  output logic rx_last_read,
  output logic tx_idle,
  output logic busy
);
  initial begin
    rx_data_read = 1'b0;
    rx_packet_start = 1'b0;
    rx_last_read = 1'b0;
    tx_idle = 1'b1;
    busy = 1'b0;
  end
  // ==========================================================
  // Receive reader: reads data only, never the filler DWORDs
  always begin
    @(posedge core_clk iff pkt_go);
    #1 busy = 1'b1;
    rx_packet_start = 1'b1;
    @(posedge core_clk);
    #1 rx_packet_start = 1'b0;
    for (int i = 0; i < pkt_len; i++) begin
      rx_data_read = 1'b1;
      rx_last_read = (i == pkt_len - 1);
      @(posedge core_clk);
      #1 rx_data_read = 1'b0;
      rx_last_read = 1'b0;
      if (slow) begin
        @(posedge core_clk);
        #1;
      end
    end
    busy = 1'b0;
  end
  // ==========================================================
  // Transmit frame of eight cycles
  always begin
    @(posedge core_clk iff frame_go);
    #1 tx_idle = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 tx_idle = 1'b1;
  end
endmodule

// ===== tb/mac_fifo_rx_tx_config_tb_top.sv
// Testbench for the FIFO configuration register bank
`timescale 1ns/1ps
module mac_fifo_rx_tx_config_tb_top;
  localparam logic [7:0] RX = mfrtc_pkg::RECV_CONF_OFS;
  localparam logic [7:0] TX = mfrtc_pkg::XMIT_CONF_OFS;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_cs = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic tx_status_full = 1'b0, pkt_go = 1'b0, slow = 1'b0, frame_go = 1'b0;
  logic [3:0] pkt_len = 4'h0;
  logic [31:0] reg_rdata;
  logic rx_data_read, rx_packet_start, rx_last_read, tx_idle, busy, rx_dma_event;
  logic rx_fifo_purge, rx_pad_valid, transmit_status_purge, tx_data_purge, tx_enable;
  logic tx_stop_req, tx_run, tx_halted, tx_status_full_event;
  logic [2:0] rx_dword_offset, rx_pad_count;
  logic [1:0] rx_byte_offset;
  logic [2:0] pad_seen = 3'h0;
  int fails = 0, checked = 0, cycles = 0, ev_n = 0, pad_n = 0, full_n = 0, halt_n = 0;

  mfrtc_top u_mfrtc_top (.core_clk, .rst_n, .reg_cs, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .rx_data_read, .rx_packet_start, .rx_last_read,
    .tx_status_full, .tx_idle, .rx_dma_event, .rx_fifo_purge, .rx_dword_offset,
    .rx_byte_offset, .rx_pad_count, .rx_pad_valid, .transmit_status_purge,
    .tx_data_purge, .tx_enable, .tx_stop_req, .tx_run, .tx_halted, .tx_status_full_event);
  mfrtc_host_model u_mfrtc_host_model (.core_clk, .pkt_go, .pkt_len, .slow, .frame_go,
    .rx_data_read, .rx_packet_start, .rx_last_read, .tx_idle, .busy);

  always #2.5 core_clk = ~core_clk;
  // ==========================================================
  // Event monitors
  always @(posedge core_clk) begin
    if (rx_dma_event === 1'b1) ev_n <= ev_n + 1;
    if (tx_status_full_event === 1'b1) full_n <= full_n + 1;
    if (tx_halted === 1'b1) halt_n <= halt_n + 1;
    if (rx_pad_valid === 1'b1) begin
      pad_n <= pad_n + 1;
      pad_seen <= rx_pad_count;
    end
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      close_out();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    idle(1);
    reg_cs = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    idle(1);
    reg_cs = 1'b0;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    idle(1);
    reg_cs = 1'b1;
    reg_rd = 1'b1;
    reg_addr = a;
    idle(1);
    reg_cs = 1'b0;
    reg_rd = 1'b0;
    chk(reg_rdata, exp, msg);
  endtask
  task automatic run_pkt(input logic [3:0] n);
    int k;
    pkt_len = n;
    pkt_go = 1'b1;
    idle(1);
    pkt_go = 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      #2;
      k++;
    end while (busy === 1'b1 && k < 60);
    idle(3);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(RX, 32'h0, "rx config reset");
    rd(TX, 32'h0, "tx config reset");
    rd(8'h74, 32'h0, "unmapped read");
    chk({tx_enable, tx_stop_req, tx_run}, 3'h0, "tx outputs reset");
  endtask
  task automatic t_count;
    wr(RX, 32'h80030500);
    rd(RX, 32'h80030500, "count loaded");
    run_pkt(4'h3);
    chk(ev_n, 1, "event on drain");
    rd(RX, 32'h80000500, "count held at zero");
    run_pkt(4'h2);
    chk(ev_n, 1, "no event at zero");
    wr(RX, 32'h80050500);
    run_pkt(4'h2);
    rd(RX, 32'h80030500, "count after two reads");
    wr(RX, 32'h80010500);
    run_pkt(4'h1);
    chk(ev_n, 2, "rewritten count drains");
  endtask
  task automatic t_pad;
    logic [2:0] pad_exp;
    int base;
    // Earlier packets already raised filler pulses
    base = pad_n;
    for (int c = 0; c < 4; c++) begin
      // Alignment changes only between packets
      wr(RX, {c[1:0], 30'h0});
      // Three data DWORDs fill up to four or eight
      pad_exp = (c == 1) ? 3'h1 : (c == 2) ? 3'h5 : 3'h0;
      slow = (c == 2);
      run_pkt(4'h3);
      chk(pad_seen, pad_exp, "filler count");
      chk(pad_n, base + c + 1, "filler valid pulse");
    end
    slow = 1'b0;
  endtask
  task automatic t_offset;
    // Low offset bits change only with the reader idle
    wr(RX, 32'h00000d00);
    idle(1);
    chk(rx_byte_offset, 2'h1, "byte offset");
    chk(rx_dword_offset, 3'h0, "dword offset before read");
    run_pkt(4'h1);
    chk(rx_dword_offset, 3'h3, "dword offset");
    wr(RX, 32'h00001d00);
    idle(2);
    chk(rx_dword_offset, 3'h3, "dword offset waits for read");
    run_pkt(4'h1);
    chk(rx_dword_offset, 3'h7, "dword offset live change");
  endtask
  task automatic t_purge;
    wr(RX, 32'h00008000);
    chk(rx_fifo_purge, 1'b1, "rx purge pulse");
    idle(1);
    chk(rx_fifo_purge, 1'b0, "rx purge self clear");
    rd(RX, 32'h0, "rx purge reads clear");
    wr(TX, 32'h00008000);
    chk({transmit_status_purge, tx_data_purge}, 2'h2, "status purge");
    wr(TX, 32'h00004000);
    chk({transmit_status_purge, tx_data_purge}, 2'h1, "data purge");
    idle(1);
    chk({transmit_status_purge, tx_data_purge}, 2'h0, "purge self clear");
  endtask
  task automatic t_tx;
    int k;
    wr(TX, 32'h2);
    chk({tx_enable, tx_run}, 2'h3, "transmitter on");
    tx_status_full = 1'b1;
    idle(2);
    chk(tx_run, 1'b0, "suspend on full");
    chk(full_n, 1, "full event");
    wr(TX, 32'h6);
    // Stored permit reaches the run gate one cycle after the write
    idle(1);
    chk(tx_run, 1'b1, "overrun permitted");
    tx_status_full = 1'b0;
    idle(1);
    tx_status_full = 1'b1;
    idle(2);
    chk(full_n, 2, "full event with permit");
    tx_status_full = 1'b0;
    frame_go = 1'b1;
    idle(1);
    frame_go = 1'b0;
    wr(TX, 32'h7);
    chk(tx_stop_req, 1'b1, "stop requested");
    wr(TX, 32'h6);
    chk(tx_stop_req, 1'b1, "stop write ignored");
    chk({tx_enable, halt_n[0]}, 2'h2, "frame still running");
    k = 0;
    while (halt_n == 0 && k < 30) begin
      idle(1);
      k++;
    end
    idle(1);
    chk(halt_n, 1, "halt pulse");
    chk({tx_enable, tx_stop_req, tx_run}, 3'h0, "enable self clear");
    rd(TX, 32'h4, "tx config after stop");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_count();
    t_pad();
    t_offset();
    t_purge();
    t_tx();
    close_out();
  end
endmodule
